//--- src/gcs_mmd_window.sv
`timescale 1ns/10ps
module gcs_mmd_window
   import gcs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   gcs_win_if.win win,
   output logic mmd_req,
   output logic mmd_we,
   output logic [4:0] mmd_dev,
   output logic [15:0] mmd_addr,
   output logic [15:0] mmd_wdata,
   input wire logic [15:0] mmd_rdata,
   input wire logic mmd_ack
);

   gcs_win_state_e state_r;
   logic [15:0] addr_r;
   logic [15:0] rdata_r;
   logic done_r;
   logic bump;

   assign bump = (state_r == WIN_BUSY) && mmd_ack &&
      ((win.func == FN_INC_RW) || ((win.func == FN_INC_WR) && mmd_we));

   // ****************************************************************
   // Transfer sequencer.
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= WIN_IDLE;
         mmd_req <= 1'b0;
         mmd_we <= 1'b0;
         mmd_dev <= 5'h00;
         mmd_wdata <= 16'h0000;
         rdata_r <= 16'h0000;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         case (state_r)
            WIN_IDLE: begin
               if (win.start) begin
                  state_r <= WIN_BUSY;
                  mmd_req <= 1'b1;
                  mmd_we <= win.wr;
                  mmd_dev <= win.dev;
                  mmd_wdata <= win.wdata;
               end
            end
            WIN_BUSY: begin
               if (mmd_ack) begin
                  state_r <= WIN_IDLE;
                  mmd_req <= 1'b0;
                  rdata_r <= mmd_rdata;
                  done_r <= 1'b1;
               end
            end
            default: begin
               state_r <= WIN_IDLE;
               mmd_req <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // Register address within the selected device.
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r <= 16'h0000;
      end else if (win.addr_load) begin
         addr_r <= win.wdata;
      end else if (bump) begin
         addr_r <= addr_r + 16'h0001;
      end
   end

   assign mmd_addr = addr_r;
   assign win.addr = addr_r;
   assign win.rdata = rdata_r;
   assign win.done = done_r;

   chk_inc_after_ack: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == WIN_BUSY) && mmd_ack && (win.func == FN_INC_RW) && !win.addr_load
      |=> addr_r == $past(addr_r) + 16'h0001)
      else $error("address not incremented after data access");

   chk_dev_select: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == WIN_IDLE) && win.start |=> mmd_req && (mmd_dev == $past(win.dev)))
      else $error("device select not presented on request");

endmodule // gcs_mmd_window

//--- src/gcs_pkg.sv
package gcs_pkg;

   // ****************************************************************
   // Register map: word indices, byte address is four times the index.
   // ****************************************************************
   localparam int unsigned GCS_ADDR_W = 8;
   localparam logic [5:0] GCS_IDX_CTRL = 6'h09;
   localparam logic [5:0] GCS_IDX_STAT = 6'h0a;
   localparam logic [5:0] GCS_IDX_ACC = 6'h0d;
   localparam logic [5:0] GCS_IDX_DATA = 6'h0e;
   localparam logic [5:0] GCS_IDX_EXT = 6'h0f;
   localparam logic [5:0] GCS_IDX_IRQ_STAT = 6'h18;
   localparam logic [5:0] GCS_IDX_IRQ_MASK = 6'h19;

   // ****************************************************************
   // Field positions and reset values.
   // ****************************************************************
   localparam int unsigned CTRL_TEST_HI = 15;
   localparam int unsigned CTRL_TEST_LO = 13;
   localparam int unsigned CTRL_MAN_EN = 12;
   localparam int unsigned CTRL_MAN_VAL = 11;
   localparam int unsigned CTRL_PORT = 10;
   localparam int unsigned CTRL_FDX = 9;
   localparam int unsigned CTRL_HDX = 8;
   localparam logic [15:0] CTRL_RST = 16'h0700;
   localparam int unsigned STAT_FAULT = 15;
   localparam int unsigned STAT_RESOLVED = 14;
   localparam int unsigned STAT_LOCAL_RX = 13;
   localparam int unsigned STAT_REMOTE_RX = 12;
   localparam int unsigned STAT_LP_FDX = 11;
   localparam int unsigned STAT_LP_HDX = 10;
   localparam logic [7:0] IDLE_MAX = 8'hff;
   localparam logic [7:0] IDLE_NEAR_MAX = 8'hfe;
   localparam int unsigned ACC_FUNC_HI = 15;
   localparam int unsigned ACC_FUNC_LO = 14;
   localparam int unsigned ACC_DEV_HI = 4;
   localparam logic [15:0] ACC_RST = 16'h0000;
   localparam logic [15:0] EXT_VALUE = 16'h3000;

   // ****************************************************************
   // Interrupt status layout.
   // ****************************************************************
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_FAULT = 0;
   localparam int unsigned IRQ_IDLE_SAT = 1;
   localparam int unsigned IRQ_RX_LOSS = 2;

   // ****************************************************************
   // Enumerations.
   // ****************************************************************
   typedef enum logic [1:0] {
      FN_ADDR = 2'b00,
      FN_DATA = 2'b01,
      FN_INC_RW = 2'b10,
      FN_INC_WR = 2'b11
   } gcs_func_e;

   typedef enum logic [2:0] {
      TEST_NORMAL = 3'b000,
      TEST_WAVEFORM = 3'b001,
      TEST_JITTER_MASTER = 3'b010,
      TEST_JITTER_SLAVE = 3'b011,
      TEST_DISTORTION = 3'b100
   } gcs_test_e;

   typedef enum logic {
      WIN_IDLE = 1'b0,
      WIN_BUSY = 1'b1
   } gcs_win_state_e;

endpackage

//--- src/gcs_top.sv
`timescale 1ns/10ps
module gcs_top
   import gcs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [GCS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic ms_fault_in,
   input wire logic ms_resolved_master,
   input wire logic local_rx_ok,
   input wire logic remote_rx_ok,
   input wire logic link_partner_full_duplex,
   input wire logic link_partner_half_duplex,
   input wire logic idle_error,
   output logic [2:0] tx_test_mode,
   output logic ms_manual_en,
   output logic ms_force_master,
   output logic port_multi,
   output logic adv_full_duplex,
   output logic adv_half_duplex,
   output logic mmd_req,
   output logic mmd_we,
   output logic [4:0] mmd_dev,
   output logic [15:0] mmd_addr,
   output logic [15:0] mmd_wdata,
   input wire logic [15:0] mmd_rdata,
   input wire logic mmd_ack
);

   // ****************************************************************
   // Address decode.
   // ****************************************************************
   function automatic logic hit(input logic [GCS_ADDR_W-1:0] a, input logic [5:0] idx);
      hit = (a[1:0] == 2'b00) && (a[GCS_ADDR_W-1:2] == idx);
   endfunction

   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic irq_r;
   logic [15:0] ctrl_r;
   logic [15:0] acc_r;
   logic [2:0] test_r;
   logic force_master_r;
   logic fault_r;
   logic resolved_r, local_r, remote_r, lp_fdx_r, lp_hdx_r;
   logic [7:0] idle_cnt_r;
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic [IRQ_W-1:0] irq_ev;
   logic mmd_busy_r;
   logic access;
   logic hit_ctrl, hit_stat, hit_acc, hit_data, hit_ext, hit_istat, hit_imask;
   logic mapped;
   logic mmd_data;
   logic go;
   logic respond;
   logic rd_take;
   logic wr_commit;
   logic stat_clr;
   logic [15:0] stat_word;
   logic [15:0] rd_mux;
   logic [2:0] test_field;

   gcs_win_if win_if ();

   assign access = psel && penable;
   assign hit_ctrl = hit(paddr, GCS_IDX_CTRL);
   assign hit_stat = hit(paddr, GCS_IDX_STAT);
   assign hit_acc = hit(paddr, GCS_IDX_ACC);
   assign hit_data = hit(paddr, GCS_IDX_DATA);
   assign hit_ext = hit(paddr, GCS_IDX_EXT);
   assign hit_istat = hit(paddr, GCS_IDX_IRQ_STAT);
   assign hit_imask = hit(paddr, GCS_IDX_IRQ_MASK);
   assign mapped = hit_ctrl | hit_stat | hit_acc | hit_data | hit_ext | hit_istat | hit_imask;

   // Data function goes to the window.
   assign mmd_data = hit_data && (win_if.func != FN_ADDR);
   assign go = !mmd_data || win_if.done;
   assign respond = access && !pready_r && go;
   assign rd_take = respond && !pwrite;
   assign wr_commit = access && pready_r && pwrite && !pslverr_r;
   assign stat_clr = rd_take && hit_stat;

   // ****************************************************************
   // APB response.
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= respond;
         pslverr_r <= respond && !mapped;
         if (rd_take) begin
            prdata_r <= {16'h0000, rd_mux};
         end
      end
   end

   always_comb begin
      rd_mux = 16'h0000;
      if (hit_ctrl) begin
         rd_mux = ctrl_r;
      end else if (hit_stat) begin
         rd_mux = stat_word;
      end else if (hit_acc) begin
         rd_mux = acc_r;
      end else if (hit_data) begin
         rd_mux = (win_if.func == FN_ADDR) ? win_if.addr : win_if.rdata;
      end else if (hit_ext) begin
         rd_mux = EXT_VALUE;
      end else if (hit_istat) begin
         rd_mux = {{(16 - IRQ_W){1'b0}}, irq_stat_r};
      end else if (hit_imask) begin
         rd_mux = {{(16 - IRQ_W){1'b0}}, irq_mask_r};
      end
   end

   // ****************************************************************
   // Gigabit control register and its outputs.
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_commit && hit_ctrl) begin
         ctrl_r <= pwdata[15:0];
      end
   end

   assign test_field = ctrl_r[CTRL_TEST_HI:CTRL_TEST_LO];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_r <= TEST_NORMAL;
         force_master_r <= 1'b0;
      end else begin
         case (test_field)
            TEST_WAVEFORM: test_r <= TEST_WAVEFORM;
            TEST_JITTER_MASTER: test_r <= TEST_JITTER_MASTER;
            TEST_JITTER_SLAVE: test_r <= TEST_JITTER_SLAVE;
            TEST_DISTORTION: test_r <= TEST_DISTORTION;
            default: test_r <= TEST_NORMAL;
         endcase
         force_master_r <= ctrl_r[CTRL_MAN_EN] && ctrl_r[CTRL_MAN_VAL];
      end
   end

   assign tx_test_mode = test_r;
   assign ms_manual_en = ctrl_r[CTRL_MAN_EN];
   assign ms_force_master = force_master_r;
   assign port_multi = ctrl_r[CTRL_PORT];
   assign adv_full_duplex = ctrl_r[CTRL_FDX];
   assign adv_half_duplex = ctrl_r[CTRL_HDX];

   // ****************************************************************
   // Gigabit status register.
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resolved_r <= 1'b1;
         local_r <= 1'b0;
         remote_r <= 1'b0;
         lp_fdx_r <= 1'b0;
         lp_hdx_r <= 1'b0;
      end else begin
         resolved_r <= ms_resolved_master;
         local_r <= local_rx_ok;
         remote_r <= remote_rx_ok;
         lp_fdx_r <= link_partner_full_duplex;
         lp_hdx_r <= link_partner_half_duplex;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_r <= 1'b0;
      end else begin
         fault_r <= ms_fault_in || (fault_r && !stat_clr);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_r <= 8'h00;
      end else if (stat_clr) begin
         // Clear on read keeps new error.
         idle_cnt_r <= idle_error ? 8'h01 : 8'h00;
      end else if (idle_error && (idle_cnt_r != IDLE_MAX)) begin
         idle_cnt_r <= idle_cnt_r + 8'h01;
      end
   end

   assign stat_word = {fault_r, resolved_r, local_r, remote_r, lp_fdx_r, lp_hdx_r, 2'b00,
      idle_cnt_r};

   // ****************************************************************
   // Indirect access control and window hookup.
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r <= ACC_RST;
      end else if (wr_commit && hit_acc) begin
         // Device select and reserved bits stored.
         acc_r <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mmd_busy_r <= 1'b0;
      end else if (win_if.done) begin
         mmd_busy_r <= 1'b0;
      end else if (win_if.start) begin
         mmd_busy_r <= 1'b1;
      end
   end

   assign win_if.func = gcs_func_e'(acc_r[ACC_FUNC_HI:ACC_FUNC_LO]);
   assign win_if.dev = acc_r[ACC_DEV_HI:0];
   assign win_if.start = access && !pready_r && mmd_data && !mmd_busy_r && !win_if.done;
   assign win_if.wr = pwrite;
   assign win_if.wdata = pwdata[15:0];
   assign win_if.addr_load = wr_commit && hit_data && (win_if.func == FN_ADDR);

   gcs_mmd_window u_window (
      .pclk(pclk),
      .presetn(presetn),
      .win(win_if.win),
      .mmd_req(mmd_req),
      .mmd_we(mmd_we),
      .mmd_dev(mmd_dev),
      .mmd_addr(mmd_addr),
      .mmd_wdata(mmd_wdata),
      .mmd_rdata(mmd_rdata),
      .mmd_ack(mmd_ack)
   );

   // ****************************************************************
   // Interrupts.
   // ****************************************************************
   assign irq_ev[IRQ_FAULT] = ms_fault_in;
   assign irq_ev[IRQ_IDLE_SAT] = idle_error && !stat_clr && (idle_cnt_r == IDLE_NEAR_MAX);
   assign irq_ev[IRQ_RX_LOSS] = local_r && !local_rx_ok;

   genvar gi;
   generate
      for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               irq_stat_r[gi] <= 1'b0;
            end else begin
               irq_stat_r[gi] <= irq_ev[gi] ||
                  (irq_stat_r[gi] && !(wr_commit && hit_istat && pwdata[gi]));
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_r <= '0;
         irq_r <= 1'b0;
      end else begin
         if (wr_commit && hit_imask) begin
            irq_mask_r <= pwdata[IRQ_W-1:0];
         end
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_test_reserved: assert property (
      test_field > TEST_DISTORTION |=> tx_test_mode == TEST_NORMAL)
      else $error("reserved test code not mapped to normal");
   chk_test_follow: assert property (
      test_field <= TEST_DISTORTION |=> tx_test_mode == $past(test_field))
      else $error("test mode output does not follow control field");
   chk_manual_gate: assert property (
      !ctrl_r[CTRL_MAN_EN] |=> !ms_force_master)
      else $error("master forced without manual enable");
   chk_manual_value: assert property (
      ctrl_r[CTRL_MAN_EN] |=> ms_force_master == $past(ctrl_r[CTRL_MAN_VAL]))
      else $error("manual value not applied");
   chk_adv_write: assert property (
      wr_commit && hit_ctrl |=> adv_full_duplex == $past(pwdata[CTRL_FDX]) &&
         adv_half_duplex == $past(pwdata[CTRL_HDX]) && port_multi == $past(pwdata[CTRL_PORT]))
      else $error("advertise bits not written");
   chk_fault_latch: assert property (
      ms_fault_in |=> stat_word[STAT_FAULT])
      else $error("fault bit did not latch");
   chk_fault_hold: assert property (
      fault_r && !stat_clr |=> fault_r)
      else $error("fault bit dropped without a read");
   chk_fault_clear: assert property (
      stat_clr && !ms_fault_in |=> !fault_r)
      else $error("fault bit not cleared by read");
   chk_resolve_track: assert property (
      1'b1 |=> stat_word[STAT_RESOLVED] == $past(ms_resolved_master))
      else $error("resolution bit does not track role");
   chk_rx_status: assert property (
      1'b1 |=> stat_word[STAT_LOCAL_RX] == $past(local_rx_ok) &&
         stat_word[STAT_REMOTE_RX] == $past(remote_rx_ok))
      else $error("receiver status bits wrong");
   chk_lp_caps: assert property (
      1'b1 |=> stat_word[STAT_LP_FDX] == $past(link_partner_full_duplex) &&
         stat_word[STAT_LP_HDX] == $past(link_partner_half_duplex))
      else $error("partner ability bits wrong");
   chk_idle_clear: assert property (
      stat_clr && !idle_error ##1 !idle_error |=> idle_cnt_r == 8'h00)
      else $error("idle count not cleared by read");
   chk_addr_load: assert property (
      win_if.addr_load |=> win_if.addr == $past(pwdata[15:0]))
      else $error("address phase write not stored");
   chk_ext_value: assert property (
      rd_take && hit_ext |=> prdata[15:0] == EXT_VALUE && pready)
      else $error("extended status word wrong");

endmodule // gcs_top

//--- src/gcs_win_if.sv
`timescale 1ns/10ps
interface gcs_win_if;
   import gcs_pkg::*;
   gcs_func_e func;
   logic [4:0] dev;
   logic start;
   logic wr;
   logic [15:0] wdata;
   logic addr_load;
   logic done;
   logic [15:0] rdata;
   logic [15:0] addr;

   modport regs (output func, dev, start, wr, wdata, addr_load, input done, rdata, addr);
   modport win (input func, dev, start, wr, wdata, addr_load, output done, rdata, addr);
endinterface

//--- tb/gcs_mmd_model.sv
`timescale 1ns/10ps
module gcs_mmd_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   input wire logic we,
   input wire logic [4:0] dev,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic slow,
   output logic [15:0] rdata,
   output logic ack
);
   logic [15:0] mem [16];
   logic [2:0] cnt;
   logic done;
   // Read data carries the device select so a wrong select shows up in the value.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 3'h0;
         ack <= 1'b0;
         done <= 1'b0;
         rdata <= 16'h0;
      end else begin
         ack <= 1'b0;
         rdata <= ~rdata;
         if (ack) begin
            done <= 1'b1;
         end else if (!req) begin
            done <= 1'b0;
         end
         if (req && !done && !ack) begin
            cnt <= cnt + 3'h1;
            if (cnt == (slow ? 3'h4 : 3'h0)) begin
               ack <= 1'b1;
               cnt <= 3'h0;
               if (we) begin
                  mem[addr[3:0]] <= wdata;
               end
               rdata <= mem[addr[3:0]] ^ {11'h0, dev};
            end
         end
      end
   end
endmodule // gcs_mmd_model

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
   import gcs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, x, st = 32'd77;
   logic er, ms_fault_in = 0, ms_res = 1, lrx = 0, rrx = 0, lpf = 0, lph = 0, idle = 0;
   logic [2:0] tmode;
   logic man, fm, pm, afd, ahd, req, we, ack, slow = 0;
   logic [4:0] dev;
   logic [15:0] maddr, mwd, mrd, v, d0, d1, d2;
   int mismatches = 0, checks = 0, cyc = 0, i, k;
   always #10 pclk = ~pclk;
   gcs_top gcs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .ms_fault_in(ms_fault_in), .ms_resolved_master(ms_res),
      .local_rx_ok(lrx), .remote_rx_ok(rrx), .link_partner_full_duplex(lpf),
      .link_partner_half_duplex(lph), .idle_error(idle), .tx_test_mode(tmode),
      .ms_manual_en(man), .ms_force_master(fm), .port_multi(pm), .adv_full_duplex(afd),
      .adv_half_duplex(ahd), .mmd_req(req), .mmd_we(we), .mmd_dev(dev), .mmd_addr(maddr),
      .mmd_wdata(mwd), .mmd_rdata(mrd), .mmd_ack(ack));
   gcs_mmd_model gcs_mmd_model_i (.pclk(pclk), .presetn(presetn), .req(req), .we(we),
      .dev(dev), .addr(maddr), .wdata(mwd), .slow(slow), .rdata(mrd), .ack(ack));
   function automatic logic [31:0] rnd();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction
   function automatic logic [2:0] exp_mode(input logic [15:0] c);
      return (c[15:13] > 3'h4) ? 3'h0 : c[15:13];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 8'h24, 0);
      chk(rd, 32'h0700);
      chk(er, 1'b0);
      chk({pm, afd, ahd, man, fm}, 5'h1c);
      apb(0, 8'h28, 0);
      chk(rd, 32'h4000);
      apb(1, 8'h3c, 16'hffff);
      apb(0, 8'h3c, 0);
      chk(rd, 32'h3000);
      apb(0, 8'h34, 0);
      chk(rd, 32'h0);
      apb(0, 8'h44, 0);
      chk(er, 1'b1);
      apb(0, 8'h26, 0);
      chk(er, 1'b1);
      for (i = 0; i < 12; i++) begin
         x = rnd();
         v = (i < 8) ? {i[2:0], x[12:0]} : x[15:0];
         apb(1, 8'h24, v);
         apb(0, 8'h24, 0);
         chk(rd, {16'h0, v});
         chk(tmode, exp_mode(v));
         chk({man, fm}, {v[12], v[12] & v[11]});
         chk({pm, afd, ahd}, v[10:8]);
      end
      for (i = 0; i < 6; i++) begin
         x = rnd();
         {ms_res, lrx, rrx, lpf, lph} <= x[4:0];
         apb(0, 8'h28, 0);
         chk(rd[14:8], {x[4:0], 2'b00});
      end
      ms_fault_in <= 1'b1;
      @(posedge pclk) ms_fault_in <= 1'b0;
      apb(0, 8'h28, 0);
      chk(rd[15], 1'b1);
      apb(0, 8'h28, 0);
      chk(rd[15], 1'b0);
      for (i = 0; i < 2; i++) begin
         k = i ? 300 : rnd() % 20 + 1;
         idle <= 1'b1;
         repeat (k) @(posedge pclk);
         idle <= 1'b0;
         apb(0, 8'h28, 0);
         chk(rd[7:0], (k > 255) ? 255 : k);
         apb(0, 8'h28, 0);
         chk(rd[7:0], 8'h00);
      end
      apb(0, 8'h60, 0);
      chk(rd[1], 1'b1);
      apb(1, 8'h64, 0);
      apb(1, 8'h60, 7);
      apb(0, 8'h60, 0);
      chk(rd, 0);
      ms_fault_in <= 1'b1;
      @(posedge pclk) ms_fault_in <= 1'b0;
      apb(0, 8'h60, 0);
      chk(rd, 1);
      chk(irq, 1'b0);
      apb(1, 8'h64, 1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      apb(1, 8'h60, 1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      lrx <= 1'b1;
      repeat (2) @(posedge pclk);
      lrx <= 1'b0;
      apb(0, 8'h60, 0);
      chk(rd, 4);
      x = rnd();
      {d0, d1} = x;
      x = rnd();
      d2 = x[15:0];
      apb(1, 8'h34, 16'h0005);
      apb(1, 8'h38, 2);
      apb(0, 8'h38, 0);
      chk(rd, 2);
      apb(1, 8'h34, 16'h8005);
      apb(1, 8'h38, d0);
      apb(1, 8'h38, d1);
      apb(1, 8'h34, 16'h0005);
      apb(1, 8'h38, 2);
      slow <= 1'b1;
      apb(1, 8'h34, 16'h4005);
      apb(0, 8'h38, 0);
      chk(rd, d0 ^ 16'h5);
      apb(0, 8'h38, 0);
      chk(rd, d0 ^ 16'h5);
      apb(1, 8'h34, 16'hc01a);
      apb(0, 8'h38, 0);
      chk(rd, d0 ^ 16'h1a);
      apb(1, 8'h38, d2);
      apb(0, 8'h38, 0);
      chk(rd, d1 ^ 16'h1a);
      apb(1, 8'h34, 16'h0005);
      apb(1, 8'h38, 2);
      apb(1, 8'h34, 16'h8005);
      apb(0, 8'h38, 0);
      chk(rd, d2 ^ 16'h5);
      apb(0, 8'h38, 0);
      chk(rd, d1 ^ 16'h5);
      complete_run();
   end
endmodule // testbench
